/* File: rtl/pmx_cfg.svh */
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

// Register byte offsets; ports sit at a stride of 16 bytes
`define PMX_PORT_STRIDE 8'h10
`define PMX_OFF_CTL     8'h00
`define PMX_OFF_DIR     8'h04
`define PMX_OFF_DAT     8'h08
`define PMX_OFF_PIN     8'h0C
`define PMX_OFF_IEN     8'h40
`define PMX_OFF_CHIP    8'h44

// Chip config fields
`define PMX_CHIP_ALT_A  0
`define PMX_CHIP_ALT_D  1
`define PMX_CHIP_STRAP  8

// Reset values
`define PMX_RST_WORD    32'h0000_0000
`define PMX_RST_ALT     2'h0

// Implemented lines, per revision
`define PMX_A_IN        32'h1FFF_FFFF
`define PMX_A_OUT       32'h00FF_FFFF
`define PMX_A_IRQ_CAP   32'h1FFF_FDBF
`define PMX_B_IN_EARLY  32'h0000_0000
`define PMX_B_IN_LATE   32'h0000_0001
`define PMX_B_OUT       32'h0000_0000
`define PMX_C_IN_EARLY  32'h0000_03FF
`define PMX_C_IN_LATE   32'h0000_07FF
`define PMX_C_OUT       32'h0000_03FF
`define PMX_D_IN_EARLY  32'h0000_0070
`define PMX_D_IN_LATE   32'h0000_01F0
`define PMX_D_OUT       32'h0000_0070

// Fixed line positions and interrupt count
`define PMX_TDM_A_LSB   6
`define PMX_TDM_B_LSB   0
`define PMX_A_CLKO_BIT  15
`define PMX_D_CLKO_BIT  7
`define PMX_IRQ_NUM     27

// Answers
`define PMX_RESP_OKAY   2'h0
`define PMX_RESP_DECERR 2'h3

`endif

/* File: rtl/pmx_pkg.sv */
package pmx_pkg;

    typedef logic [31:0] pmx_word_t;

    typedef enum logic [2:0] {
        PMX_R_NONE = 3'h0,
        PMX_R_CTL  = 3'h1,
        PMX_R_DIR  = 3'h3,
        PMX_R_DAT  = 3'h2,
        PMX_R_PIN  = 3'h6,
        PMX_R_IEN  = 3'h7,
        PMX_R_CHIP = 3'h5
    } pmx_reg_e;

    typedef struct packed {
        pmx_reg_e   kind;
        logic [1:0] port;
    } pmx_dec_s;

endpackage

/* File: rtl/pmx_port_mux.sv */
// Summary of operation
// [R01] Latch strap lines when power-on reset releases
// [R02] Port registers 32 bits, partly implemented
// [R03] Implemented input lines depend on revision
// [R04] All lines reset to software-controlled input
// [R05] Non-input bit positions are reserved, inert
// [R06] Port A: 27 maskable IRQs plus NMI
// [R07] NMI line is dedicated, never reassigned
// [R08] IRQ-enabled line unavailable to other functions
// [R09] Software control plus output direction drives data
// [R10] Port A output disables its interrupt
// [R11] Output-capable lines: A 24, C 10, D 3
// [R12] Hardware control routes line to peripheral
// [R13] Port A hardware control disables interrupt
// [R14] Software enables all lines a peripheral needs
// [R15] Alternate needs hardware control and select bit
// [R16] Alternate function is a clock output
// [R17] Alternate function displaces primary hardware signal
// [R18] A11..A9: first TDM receive clock, sync, data
// [R19] A8..A6: first TDM transmit clock, sync, data
// [R20] A5..A3: second TDM receive clock, sync, data
// [R21] A2..A0: second TDM transmit clock, sync, data
// [R22] Control bit 1 hardware; direction bit 1 output
// [R23] Unimplemented bits read zero, writes ignored
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_port_mux #(
    parameter int ADDR_W  = 8,
    parameter int STRAP_W = 4
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [ADDR_W-1:0]        awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    input  wire logic [ADDR_W-1:0]        araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    input  wire logic                     power_on_reset_in_n,
    input  wire logic [STRAP_W-1:0]       cfg_strap_in,
    input  wire logic [3:0][31:0]         pin_in,
    output logic [3:0][31:0]              pin_out,
    output logic [3:0][31:0]              pin_oe_n,
    input  wire logic [3:0][31:0]         hw_out,
    input  wire logic [3:0][31:0]         hw_oe,
    output logic [3:0][31:0]              hw_in,
    input  wire logic [5:0]               tdm_a_out,
    input  wire logic [5:0]               tdm_a_oe,
    output logic [5:0]                    tdm_a_in,
    input  wire logic [5:0]               tdm_b_out,
    input  wire logic [5:0]               tdm_b_oe,
    output logic [5:0]                    tdm_b_in,
    input  wire logic                     alt_clock_in,
    output logic [`PMX_IRQ_NUM-1:0]       irq_req_out,
    input  wire logic                     nmi_pin_n_in,
    output logic                          nmi_out
);

    ////////////////////////////////////////////////////////////////////////
    if (ADDR_W < 8 || STRAP_W < 1 || STRAP_W > 8) begin : g_bad_param
        $error("pmx_port_mux: ADDR_W must be >= 8 and STRAP_W 1..8");
    end

    function automatic pmx_pkg::pmx_word_t impl_mask(input logic [1:0] p, input logic late);
        pmx_pkg::pmx_word_t m;
        m = `PMX_A_IN;
        unique case (p)
            2'd0: m = `PMX_A_IN;
            2'd1: m = late ? `PMX_B_IN_LATE : `PMX_B_IN_EARLY;
            2'd2: m = late ? `PMX_C_IN_LATE : `PMX_C_IN_EARLY;
            2'd3: m = late ? `PMX_D_IN_LATE : `PMX_D_IN_EARLY;
        endcase
        return m;
    endfunction

    function automatic pmx_pkg::pmx_word_t out_mask(input logic [1:0] p);
        pmx_pkg::pmx_word_t m;
        m = `PMX_A_OUT;
        unique case (p)
            2'd0: m = `PMX_A_OUT;
            2'd1: m = `PMX_B_OUT;
            2'd2: m = `PMX_C_OUT;
            2'd3: m = `PMX_D_OUT;
        endcase
        return m;
    endfunction

    function automatic pmx_pkg::pmx_word_t merge(input pmx_pkg::pmx_word_t o, input pmx_pkg::pmx_word_t n,
                                                 input logic [3:0] s);
        pmx_pkg::pmx_word_t r;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic pmx_pkg::pmx_dec_s dec(input logic [ADDR_W-1:0] a);
        pmx_pkg::pmx_dec_s r;
        r.port = a[5:4];
        r.kind = pmx_pkg::PMX_R_NONE;
        if (a[ADDR_W-1:6] == '0 && a[1:0] == 2'h0) begin
            unique case (a[3:2])
                2'd0: r.kind = pmx_pkg::PMX_R_CTL;
                2'd1: r.kind = pmx_pkg::PMX_R_DIR;
                2'd2: r.kind = pmx_pkg::PMX_R_DAT;
                2'd3: r.kind = pmx_pkg::PMX_R_PIN;
            endcase
        end else if (a == ADDR_W'(`PMX_OFF_IEN)) begin
            r.kind = pmx_pkg::PMX_R_IEN;
        end else if (a == ADDR_W'(`PMX_OFF_CHIP)) begin
            r.kind = pmx_pkg::PMX_R_CHIP;
        end
        return r;
    endfunction

    // Interrupt number carried by each port A bit; 31 means none
    function automatic logic [4:0] irq_of_bit(input int b);
        logic [4:0] n;
        n = 5'h1F;
        unique case (b)
            0:  n = 5'd11;
            1:  n = 5'd10;
            2:  n = 5'd9;
            3:  n = 5'd8;
            4:  n = 5'd1;
            5:  n = 5'd0;
            7:  n = 5'd7;
            8:  n = 5'd6;
            10: n = 5'd5;
            11: n = 5'd4;
            12: n = 5'd2;
            13: n = 5'd3;
            default: n = (b >= 14 && b <= 28) ? 5'(b - 2) : 5'h1F;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration state
    // [R02] Full-width port registers
    logic [3:0][31:0]     ctl_q, ctl_d;
    logic [3:0][31:0]     dir_q, dir_d;
    logic [3:0][31:0]     dat_q, dat_d;
    logic [31:0]          ien_q, ien_d;
    logic [1:0]           alt_q, alt_d;
    logic [STRAP_W-1:0]   strap_q;
    logic                 por_prev_q;
    logic [3:0][31:0]     impl;

    // Bus side state
    logic [ADDR_W-1:0]    aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 aw_have_q, w_have_q;
    logic                 do_wr;
    pmx_pkg::pmx_dec_s    wdec, rdec;
    logic [31:0]          rword;

    // Lowest strap selects the later revision
    wire late_rev = strap_q[0];

    // [R01] Straps caught on release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_prev_q <= 1'b0;
            strap_q    <= '0;
        end else begin
            por_prev_q <= power_on_reset_in_n;
            if (power_on_reset_in_n && !por_prev_q) begin
                strap_q <= cfg_strap_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read in flight
    assign do_wr = aw_have_q && w_have_q && !bvalid;
    assign wdec  = dec(aw_addr_q);
    assign rdec  = dec(araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `PMX_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            aw_have_q <= (aw_have_q || (awvalid && awready)) && !do_wr;
            w_have_q  <= (w_have_q || (wvalid && wready)) && !do_wr;
            awready   <= !(aw_have_q || (awvalid && awready)) && !bvalid && !do_wr;
            wready    <= !(w_have_q || (wvalid && wready)) && !bvalid && !do_wr;
            bvalid    <= do_wr || (bvalid && !bready);
            if (do_wr) begin
                bresp <= (wdec.kind inside {pmx_pkg::PMX_R_NONE, pmx_pkg::PMX_R_PIN})
                         ? `PMX_RESP_DECERR : `PMX_RESP_OKAY;
            end
        end
    end

    // [R23] Read view masked to implemented lines
    always_comb begin
        rword = '0;
        unique case (rdec.kind)
            pmx_pkg::PMX_R_CTL:  rword = ctl_q[rdec.port];
            pmx_pkg::PMX_R_DIR:  rword = dir_q[rdec.port];
            pmx_pkg::PMX_R_DAT:  rword = dat_q[rdec.port];
            pmx_pkg::PMX_R_PIN:  rword = pin_in[rdec.port] & impl[rdec.port];
            pmx_pkg::PMX_R_IEN:  rword = ien_q;
            pmx_pkg::PMX_R_CHIP: rword = 32'({strap_q, 6'h00, alt_q});
            pmx_pkg::PMX_R_NONE: rword = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `PMX_RESP_OKAY;
        end else begin
            arready <= !(arvalid && arready) && !(rvalid && !rready);
            rvalid  <= (arvalid && arready) || (rvalid && !rready);
            if (arvalid && arready) begin
                rdata <= rword;
                rresp <= (rdec.kind == pmx_pkg::PMX_R_NONE) ? `PMX_RESP_DECERR : `PMX_RESP_OKAY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register update
    always_comb begin
        ctl_d = ctl_q;
        dir_d = dir_q;
        dat_d = dat_q;
        ien_d = ien_q;
        alt_d = alt_q;
        if (do_wr) begin
            unique case (wdec.kind)
                // [R22] Control and direction bits
                pmx_pkg::PMX_R_CTL: ctl_d[wdec.port] = merge(ctl_q[wdec.port], w_data_q, w_strb_q)
                                                      & impl[wdec.port];
                pmx_pkg::PMX_R_DIR: dir_d[wdec.port] = merge(dir_q[wdec.port], w_data_q, w_strb_q)
                                                      & impl[wdec.port];
                pmx_pkg::PMX_R_DAT: dat_d[wdec.port] = merge(dat_q[wdec.port], w_data_q, w_strb_q)
                                                      & out_mask(wdec.port);
                pmx_pkg::PMX_R_IEN: ien_d = merge(ien_q, w_data_q, w_strb_q) & `PMX_A_IRQ_CAP;
                pmx_pkg::PMX_R_CHIP: begin
                    if (w_strb_q[0]) begin
                        alt_d = w_data_q[1:0];
                    end
                end
                pmx_pkg::PMX_R_PIN: ;
                pmx_pkg::PMX_R_NONE: ;
            endcase
        end
        // [R10] Output clears interrupt enable; [R13] hardware control too
        ien_d = ien_d & ~ctl_d[0] & ~(dir_d[0] & `PMX_A_OUT);
    end

    // [R04] Reset to software-controlled input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= '0;
            dir_q <= '0;
            dat_q <= '0;
            ien_q <= `PMX_RST_WORD;
            alt_q <= `PMX_RST_ALT;
        end else begin
            ctl_q <= ctl_d;
            dir_q <= dir_d;
            dat_q <= dat_d;
            ien_q <= ien_d;
            alt_q <= alt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin multiplexing
    // [R18] [R19] TDM lines on port A bits 11..6; [R20] [R21] on 5..0
    wire [31:0] a_src_out = {hw_out[0][31:12], tdm_a_out, tdm_b_out};
    wire [31:0] a_src_oe  = {hw_oe[0][31:12], tdm_a_oe, tdm_b_oe};
    wire [31:0] irq_line  = ien_q & impl[0];

    logic [3:0][31:0] out_d, oe_d, hwin_d;

    for (genvar p = 0; p < 4; p++) begin : g_port
        // [R03] [R05] Lines beyond the revision's set stay inert
        assign impl[p] = impl_mask(2'(p), late_rev);
        wire [31:0] src_out = (p == 0) ? a_src_out : hw_out[p];
        wire [31:0] src_oe  = (p == 0) ? a_src_oe : hw_oe[p];
        wire [31:0] hw_ctl  = ctl_q[p] & impl[p];
        wire [31:0] irq_msk = (p == 0) ? irq_line : 32'h0000_0000;
        // [R11] Output only on the listed output-capable lines
        wire [31:0] sw_out  = dir_q[p] & ~hw_ctl & out_mask(2'(p));
        // [R15] [R16] Clock out needs hardware control and select
        wire        alt_on  = (p == 0) ? alt_q[`PMX_CHIP_ALT_A] : ((p == 3) ? alt_q[`PMX_CHIP_ALT_D] : 1'b0);
        wire [31:0] alt_bit = 32'h0000_0001 << ((p == 0) ? `PMX_A_CLKO_BIT : `PMX_D_CLKO_BIT);
        wire [31:0] alt_msk = alt_on ? (alt_bit & hw_ctl) : 32'h0000_0000;
        // [R17] Alternate displaces the primary signal
        wire [31:0] prim    = hw_ctl & ~alt_msk & ~irq_msk;
        // [R09] Software output; [R12] hardware routing
        assign out_d[p]  = (sw_out & dat_q[p]) | (prim & src_out) | (alt_msk & {32{alt_clock_in}});
        // [R08] Interrupt line never driven
        assign oe_d[p]   = ((sw_out | (prim & src_oe)) & ~irq_msk) | alt_msk;
        assign hwin_d[p] = pin_in[p] & prim;
    end

    // IRQ pins are active low; request is active high
    logic [`PMX_IRQ_NUM-1:0] irq_d;
    always_comb begin
        irq_d = '0;
        // [R06] Maskable requests from port A
        for (int b = 0; b < 29; b++) begin
            if (irq_of_bit(b) < 5'(`PMX_IRQ_NUM)) begin
                irq_d[irq_of_bit(b)] = irq_line[b] & ~pin_in[0][b];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out     <= '0;
            pin_oe_n    <= '1;
            hw_in       <= '0;
            tdm_a_in    <= '0;
            tdm_b_in    <= '0;
            irq_req_out <= '0;
            nmi_out     <= 1'b0;
        end else begin
            pin_out     <= out_d;
            pin_oe_n    <= ~oe_d;
            hw_in       <= hwin_d;
            tdm_a_in    <= hwin_d[0][`PMX_TDM_A_LSB +: 6];
            tdm_b_in    <= hwin_d[0][`PMX_TDM_B_LSB +: 6];
            irq_req_out <= irq_d;
            // [R07] Dedicated pin, no configuration path
            nmi_out     <= ~nmi_pin_n_in;
        end
    end

endmodule

/* File: tb/pmx_pin_partner.sv */
`timescale 1ns/10ps
module pmx_pin_partner (
    input  logic [3:0][31:0] pin_out,
    input  logic [3:0][31:0] pin_oe_n,
    input  logic [3:0][31:0] ext_lvl,
    output logic [3:0][31:0] pin_in
);
    // Far end drives only released lines, never fights the device
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule

/* File: tb/pmx_port_mux_props.sv */
`timescale 1ns/10ps
module pmx_port_mux_props (
    input logic             aclk,
    input logic             aresetn,
    input logic             awready,
    input logic             wready,
    input logic [1:0]       bresp,
    input logic             bvalid,
    input logic             bready,
    input logic             arvalid,
    input logic             arready,
    input logic             rvalid,
    input logic [3:0][31:0] pin_in,
    input logic [3:0][31:0] pin_oe_n,
    input logic [5:0]       tdm_a_in,
    input logic [5:0]       tdm_b_in,
    input logic [26:0]      irq_req_out,
    input logic             nmi_pin_n_in,
    input logic             nmi_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    chk_reset_inputs: assert property ($rose(aresetn) |-> &pin_oe_n)
        else $error("pin driven after reset");
    chk_spare_idle: assert property (&pin_oe_n[1][31:1] && &pin_oe_n[0][31:29])
        else $error("reserved line driven");
    chk_irq_src: assert property (irq_req_out[4] |-> !$past(pin_in[0][11]))
        else $error("irq 4 without low pin");
    chk_irq_b_src: assert property (irq_req_out[0] |-> !$past(pin_in[0][5]))
        else $error("irq 0 without low pin");
    chk_driven_noirq: assert property (!pin_oe_n[0][11] |-> !irq_req_out[4])
        else $error("irq on driven line");
    chk_tdm_rx: assert property (tdm_a_in[5] |-> $past(pin_in[0][11]))
        else $error("rx clock not from its pin");
    chk_tdm_tx: assert property (tdm_b_in[0] |-> $past(pin_in[0][0]))
        else $error("tx data not from its pin");
    chk_nmi_follow: assert property ($past(aresetn) |-> nmi_out == !$past(nmi_pin_n_in))
        else $error("nmi does not follow pin");
    chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    chk_w_quiet: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    chk_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    cov_wr_done: cover property (bvalid && bready);
    cov_irq: cover property (irq_req_out[4]);
    cov_tdm: cover property (tdm_b_in != 6'h00);
endmodule

bind pmx_port_mux pmx_port_mux_props chk_u (.*);

/* File: tb/tb_pmx_port_mux.sv */
`timescale 1ns/10ps
module tb_pmx_port_mux;
    logic             aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic             arvalid = 1'b0, rready = 1'b0, power_on_reset_in_n = 1'b0, nmi_pin_n_in = 1'b1;
    logic             alt_clock_in = 1'b0, awready, wready, bvalid, arready, rvalid, nmi_out;
    logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]      wdata = 32'h0000_0000, rdata, rd_v;
    logic [3:0]       wstrb = 4'hF, cfg_strap_in = 4'h1;
    logic [1:0]       bresp, rresp, rd_r, wr_r;
    logic [3:0][31:0] hw_out = '0, hw_oe = '0, ext_lvl = '1, pin_in, pin_out, pin_oe_n, hw_in;
    logic [5:0]       tdm_a_out = 6'h00, tdm_a_oe = 6'h00, tdm_b_out = 6'h00, tdm_b_oe = 6'h00;
    logic [5:0]       tdm_a_in, tdm_b_in;
    logic [26:0]      irq_req_out;
    logic [31:0]      in_late [4] = '{32'h1FFF_FFFF, 32'h0000_0001, 32'h0000_07FF, 32'h0000_01F0};
    logic [31:0]      in_early [4] = '{32'h1FFF_FFFF, 32'h0000_0000, 32'h0000_03FF, 32'h0000_0070};
    logic [31:0]      oe_e [4] = '{32'hFF00_0000, 32'hFFFF_FFFF, 32'hFFFF_FC00, 32'hFFFF_FF8F};
    int               miscompares = 0, num_checks = 0;

    pmx_port_mux dut_u (.*);
    pmx_pin_partner far_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .pin_in(pin_in));

    always #5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Address and data may be taken on different edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awready && !ta) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !tw) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        wr_r = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        rd_r = rresp;
    endtask

    // Pins lag the register update by one edge
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int p = 0; p < 4; p++) begin
            chk(pin_oe_n[p], 32'hFFFF_FFFF);
            rd(8'(p * 16));
            chk(rd_v, 32'h0000_0000);
            rd(8'(p * 16 + 12));
            chk(rd_v, in_early[p]);
        end
    endtask

    task automatic t_strap();
        power_on_reset_in_n <= 1'b1;
        settle();
        rd(8'h44);
        chk(rd_v, 32'h0000_0100);
        for (int p = 0; p < 4; p++) begin
            rd(8'(p * 16 + 12));
            chk(rd_v, in_late[p]);
        end
    endtask

    task automatic t_gpo();
        for (int p = 0; p < 4; p++) begin
            wr(8'(p * 16 + 4), 32'hFFFF_FFFF);
            wr(8'(p * 16 + 8), 32'hFFFF_FFFF);
        end
        settle();
        for (int p = 0; p < 4; p++) begin
            chk(pin_oe_n[p], oe_e[p]);
            chk(pin_out[p] | pin_oe_n[p], 32'hFFFF_FFFF);
        end
        wr(8'h08, 32'h0000_0000);
        settle();
        chk(pin_out[0] | pin_oe_n[0], 32'hFF00_0000);
        for (int p = 0; p < 4; p++) begin
            wr(8'(p * 16 + 4), 32'h0000_0000);
        end
    endtask

    task automatic t_irq();
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        chk(rd_v, 32'h1FFF_FDBF);
        ext_lvl[0] <= 32'hFFFF_F7DF;
        nmi_pin_n_in <= 1'b0;
        settle();
        chk(32'(irq_req_out), 32'h0000_0011);
        chk(32'(nmi_out), 32'h0000_0001);
        wr(8'h04, 32'h0000_0800);
        wr(8'h00, 32'h0000_0020);
        wr(8'h40, 32'hFFFF_FFFF);
        settle();
        chk(32'(irq_req_out), 32'h0000_0000);
        rd(8'h40);
        chk(rd_v, 32'h1FFF_F59F);
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0000);
        wr(8'h40, 32'h0000_0000);
        ext_lvl[0] <= '1;
        nmi_pin_n_in <= 1'b1;
    endtask

    task automatic t_tdm();
        tdm_a_oe <= 6'h3F;
        tdm_a_out <= 6'h2D;
        wr(8'h00, 32'h0000_0FFF);
        ext_lvl[0] <= 32'hFFFF_FFEA;
        settle();
        chk(32'(pin_oe_n[0][11:0]), 32'h0000_003F);
        chk(32'(pin_out[0][11:6]), 32'h0000_002D);
        chk(32'(tdm_a_in), 32'h0000_002D);
        chk(32'(tdm_b_in), 32'h0000_002A);
        wr(8'h00, 32'h0000_0000);
        tdm_a_oe <= 6'h00;
        ext_lvl[0] <= '1;
    endtask

    task automatic t_alt();
        alt_clock_in <= 1'b1;
        hw_oe[0] <= 32'h0000_8000;
        wr(8'h44, 32'h0000_0001);
        settle();
        chk(32'(pin_oe_n[0][15]), 32'h0000_0001);
        wr(8'h00, 32'h0000_8000);
        settle();
        chk(32'(pin_oe_n[0][15]), 32'h0000_0000);
        chk(32'(pin_out[0][15]), 32'h0000_0001);
        chk(32'(hw_in[0][15]), 32'h0000_0000);
        // Port A back to primary, port D alternate on
        alt_clock_in <= 1'b0;
        hw_out[0] <= 32'h0000_8000;
        wr(8'h44, 32'h0000_0002);
        wr(8'h30, 32'h0000_0080);
        settle();
        chk(32'(pin_out[0][15]), 32'h0000_0001);
        chk(32'(hw_in[0][15]), 32'h0000_0001);
        chk(32'(pin_oe_n[3][7]), 32'h0000_0000);
        wr(8'h30, 32'h0000_0000);
        wr(8'h00, 32'h0000_0000);
        wr(8'h44, 32'h0000_0000);
        hw_oe[0] <= '0;
        hw_out[0] <= '0;
    endtask

    task automatic t_bad();
        wr(8'h0C, 32'hFFFF_FFFF);
        chk(32'(wr_r), 32'h0000_0003);
        rd(8'h80);
        chk(rd_v, 32'h0000_0000);
        chk(32'(rd_r), 32'h0000_0003);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10);
        chk(rd_v, 32'h0000_0001);
        wr(8'h10, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_strap();
        t_gpo();
        t_irq();
        t_tdm();
        t_alt();
        t_bad();
        close_out();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        close_out();
    end
endmodule
